// ==== inc/pfs_pkg.sv ====
// Shared constants and types of the feature-set request block.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package pfs_pkg;
    // Setup packet fields of the accepted request.
    localparam logic [7:0]  REQ_TYPE_H2D   = 8'h00;
    localparam logic [15:0] ZERO_LENGTH    = 16'h0000;
    // Charging policy codes and the first unusable code.
    localparam logic [1:0]  POL_DEFAULT    = 2'h0;
    localparam logic [1:0]  POL_HIGH       = 2'h1;
    localparam logic [1:0]  POL_LOW        = 2'h2;
    localparam logic [1:0]  POL_NONE       = 2'h3;
    localparam logic [15:0] POL_LIMIT      = 16'h0004;
    localparam logic [1:0]  POLICY_RST     = 2'h0;
    // Wake mask layout; the status and irq mask use the ST_ positions below.
    localparam int          WAKE_BITS      = 3;
    localparam int          WAKE_ATTACH    = 0;
    localparam int          WAKE_FLOW      = 1;
    localparam int          WAKE_ERROR     = 2;
    localparam logic [2:0]  WAKE_MASK_RST  = 3'h0;
    // Register byte offsets.
    localparam logic [7:0]  ADR_CAP        = 8'h00;
    localparam logic [7:0]  ADR_STATUS     = 8'h04;
    localparam logic [7:0]  ADR_IRQ_MASK   = 8'h08;
    localparam logic [7:0]  ADR_SETTING    = 8'h0C;
    // Field positions and reset values.
    localparam int          CAP_PD_BIT     = 6;
    localparam logic [7:0]  CAP_RST        = 8'h00;
    localparam int          ST_WAKE        = 0;
    localparam int          ST_ACCEPT      = 1;
    localparam int          ST_STALL       = 2;
    localparam logic [2:0]  STATUS_RST     = 3'h0;
    localparam logic [2:0]  IRQ_MASK_RST   = 3'h0;
    localparam int          SET_POL_LSB    = 4;
    // Bus state of the device as reported by the protocol engine.
    typedef enum logic [1:0] {
        PFS_DEFAULT,
        PFS_ADDRESS,
        PFS_CONFIGURED,
        PFS_SUSPENDED
    } pfs_dev_state_t;
endpackage

// ==== inc/pfs_req_if.sv ====
// Decoded setup request between the top and its decoder.
// Assumes both ends sit in one clock domain.
`timescale 1ns/100ps
interface pfs_req_if;
    logic        valid;
    logic [7:0]  req_type;
    logic [7:0]  request;
    logic [15:0] value;
    logic [15:0] index;
    logic [15:0] length;
    logic        state_ok;
    logic        cap_ok;
    logic        take_wake;
    logic        take_charge;
    logic        reject;
    modport dec (input valid, req_type, request, value, index, length,
                 state_ok, cap_ok, output take_wake, take_charge, reject);
    modport top (output valid, req_type, request, value, index, length,
                 state_ok, cap_ok, input take_wake, take_charge, reject);
endinterface

// ==== rtl/pfs_req_decode.sv ====
// Combinational decoder of the feature-set setup request.
// Assumes the setup fields are held stable while valid is high.
`timescale 1ns/100ps
module pfs_req_decode #(
    parameter logic [7:0]  SET_FEATURE_REQ = 8'h03,
    parameter logic [15:0] WAKE_SEL        = 16'h0001,
    parameter logic [15:0] CHARGE_SEL      = 16'h0002
) (
    pfs_req_if.dec rq  // Request fields in, decision out.
);
    import pfs_pkg::*;
    wire hit;
    wire ok;
    wire is_wake;
    wire is_chg;
    // Other requests belong to other handlers and are not answered here.
    assign hit     = rq.valid && rq.req_type == REQ_TYPE_H2D
                     && rq.request == SET_FEATURE_REQ;
    assign ok      = rq.length == ZERO_LENGTH && rq.state_ok && rq.cap_ok;
    assign is_wake = rq.value == WAKE_SEL;
    assign is_chg  = rq.value == CHARGE_SEL && rq.index < POL_LIMIT;
    // Only the two selectors are taken; all else in our request stalls.
    assign rq.take_wake   = hit && ok && is_wake;
    assign rq.take_charge = hit && ok && is_chg;
    assign rq.reject      = hit && !(ok && (is_wake || is_chg));
endmodule

// ==== rtl/pfs_wake_detect.sv ====
// Per-event change detector for battery wake events.
// Assumes level inputs are synchronous to clk_i.
`timescale 1ns/100ps
module pfs_wake_detect #(
    parameter int           N        = 3,
    parameter logic [N-1:0] ANY_EDGE = '0
) (
    input  wire logic         clk_i,    // Device clock.
    input  wire logic         rst_i,    // Synchronous reset.
    input  wire logic [N-1:0] level_i,  // Event source levels.
    input  wire logic [N-1:0] mask_i,   // Per-event enables.
    output logic      [N-1:0] hit_o     // Masked event pulses.
);
    logic [N-1:0] prev;
    logic         primed;
    // The first cycle after reset only takes a baseline, so a battery
    // already present at reset does not look like a new attach.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            primed <= 1'b0;
        end else begin
            primed <= 1'b1;
        end
    end
    for (genvar g = 0; g < N; g++) begin : g_evt
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                prev[g] <= 1'b0;
            end else begin
                prev[g] <= level_i[g];
            end
        end
        // Rising edge, or any change where the event has two directions.
        assign hit_o[g] = primed && mask_i[g] && (ANY_EDGE[g]
                          ? level_i[g] != prev[g]
                          : level_i[g] && !prev[g]);
    end
endmodule

// ==== rtl/pfs_top.sv ====
// Feature-set request handler: wake mask, charging policy, registers.
// Assumes setup fields come from the control endpoint engine as a
// one-cycle strobe, and battery and power inputs are synchronous.
`timescale 1ns/100ps
// Overview of operation
// - The request is a host-to-device SET_FEATURE of type 00h, selector in wValue, argument in wIndex, no data, and its value is stored.
// - Only the battery wake selector and the charging selector are taken, each enabling its function.
// - With wake mask bit 0 set, a battery attach raises a wake event.
// - With wake mask bit 1 set, any change between charging and discharging raises a wake event.
// - With wake mask bit 2 set, a battery error raises a wake event.
// - Each of the three wake events follows the latest written mask bit on its own.
// - Charging codes 04h and up are unusable, and the policy has no effect under above-default connector current or a power contract.
// - Code 00h is the default and keeps to the default or otherwise negotiated limits.
// - Code 01h allows extra draw when unconfigured or suspended, capped at the higher of the high-power charge limit and the negotiated one; here in any state.
// - Code 02h allows extra draw when unconfigured or suspended, capped at the higher of the low-power charge limit and the negotiated one; here in any state.
// - Code 03h forbids any charging draw in every bus state.
// - The request is valid only in the Address or Configured state.
// - The request is valid only if the capability descriptor attribute bit 6 is set.
// - Every device reset returns the stored settings to 0.
module pfs_top #(
    parameter logic [7:0]  SET_FEATURE_REQ = 8'h03,
    parameter logic [15:0] WAKE_SEL        = 16'h0001,
    parameter logic [15:0] CHARGE_SEL      = 16'h0002,
    parameter int          LIMIT_W         = 16,
    parameter int unsigned HIGH_LIMIT_MA   = 1500,
    parameter int unsigned LOW_LIMIT_MA    = 500
) (
    input  wire logic                  clk_i,          // 200 MHz clock.
    input  wire logic                  rst_i,          // Sync reset.
    input  wire logic                  wb_cyc_i,       // Bus cycle.
    input  wire logic                  wb_stb_i,       // Bus strobe.
    input  wire logic                  wb_we_i,        // Write enable.
    input  wire logic [7:0]            wb_adr_i,       // Byte address.
    input  wire logic [3:0]            wb_sel_i,       // Byte lanes.
    input  wire logic [31:0]           wb_dat_i,       // Write data.
    output logic      [31:0]           wb_dat_o,       // Read data.
    output logic                       wb_ack_o,       // Acknowledge.
    output logic                       irq_o,          // Level irq.
    input  wire logic                  setup_valid_i,  // Setup strobe.
    input  wire logic [7:0]            setup_type_i,   // Request type.
    input  wire logic [7:0]            setup_req_i,    // Request code.
    input  wire logic [15:0]           setup_value_i,  // Selector.
    input  wire logic [15:0]           setup_index_i,  // Argument.
    input  wire logic [15:0]           setup_length_i, // Data length.
    input  wire logic                  bus_reset_i,    // Device reset.
    input  wire pfs_pkg::pfs_dev_state_t dev_state_i,  // Bus state.
    output logic                       req_ack_o,      // Status ok.
    output logic                       req_stall_o,    // Request error.
    input  wire logic                  battery_present_i,  // Attached.
    input  wire logic                  battery_charging_i, // Charging.
    input  wire logic                  battery_error_i,    // Error.
    output logic                       wake_event_o,   // Wake pulse.
    input  wire logic                  typec_above_default_i, // High cc.
    input  wire logic                  pd_contract_i,  // Contract held.
    input  wire logic [LIMIT_W-1:0]    negotiated_limit_i, // Other mA.
    output logic      [LIMIT_W-1:0]    charge_limit_o, // Charge cap mA.
    output logic                       charge_extra_o, // Extra allowed.
    output logic                       charge_inhibit_o // No charging.
);
    import pfs_pkg::*;

    // Refuse widths that cannot hold the charge limits.
    if (LIMIT_W < 1 || LIMIT_W > 32) begin : g_bad_w
        $error("LIMIT_W out of range");
    end
    if (HIGH_LIMIT_MA >= (64'd1 << LIMIT_W)
        || LOW_LIMIT_MA >= (64'd1 << LIMIT_W)) begin : g_bad_lim
        $error("charge limit does not fit LIMIT_W");
    end

    localparam logic [LIMIT_W-1:0] HIGH_LIM = LIMIT_W'(HIGH_LIMIT_MA);
    localparam logic [LIMIT_W-1:0] LOW_LIM  = LIMIT_W'(LOW_LIMIT_MA);

    logic [7:0]           cap;
    logic [2:0]           status;
    logic [2:0]           irq_mask;
    logic [2:0]           wake_mask;
    logic [1:0]           policy;
    logic [31:0]          next_rdata;
    logic [LIMIT_W-1:0]   next_limit;
    logic [2:0]           wake_hit;
    wire                  wb_req;
    wire                  wr_lane0;
    wire                  hit_cap;
    wire                  hit_status;
    wire                  hit_mask;
    wire                  hit_setting;
    wire                  rd_status_done;
    wire                  override;
    wire                  take_any;
    wire [2:0]            status_set;
    wire [LIMIT_W-1:0]    high_cap;
    wire [LIMIT_W-1:0]    low_cap;

    pfs_req_if rq ();

    // Request fields and validity terms for the decoder.
    assign rq.valid    = setup_valid_i && !bus_reset_i;
    assign rq.req_type = setup_type_i;
    assign rq.request  = setup_req_i;
    assign rq.value    = setup_value_i;
    assign rq.index    = setup_index_i;
    assign rq.length   = setup_length_i;
    assign rq.state_ok = dev_state_i == PFS_ADDRESS
                         || dev_state_i == PFS_CONFIGURED;
    assign rq.cap_ok   = cap[CAP_PD_BIT];

    pfs_req_decode #(
        .SET_FEATURE_REQ (SET_FEATURE_REQ),
        .WAKE_SEL        (WAKE_SEL),
        .CHARGE_SEL      (CHARGE_SEL)
    ) u_dec (
        .rq (rq)
    );

    // Flow change wakes in both directions, the others on a rising level.
    pfs_wake_detect #(
        .N        (WAKE_BITS),
        .ANY_EDGE (3'b010)
    ) u_wake (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .level_i ({battery_error_i, battery_charging_i, battery_present_i}),
        .mask_i  (wake_mask),
        .hit_o   (wake_hit)
    );

    // Wishbone decode; unmapped addresses answer with zero data.
    assign wb_req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_lane0    = wb_req && wb_we_i && wb_sel_i[0];
    assign hit_cap     = wb_adr_i == ADR_CAP;
    assign hit_status  = wb_adr_i == ADR_STATUS;
    assign hit_mask    = wb_adr_i == ADR_IRQ_MASK;
    assign hit_setting = wb_adr_i == ADR_SETTING;
    assign rd_status_done = wb_cyc_i && wb_stb_i && !wb_we_i
                            && wb_ack_o && hit_status;

    // Read multiplexer; bits above each field read as zero.
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit_cap) begin
            next_rdata[7:0] = cap;
        end else if (hit_status) begin
            next_rdata[2:0] = status;
        end else if (hit_mask) begin
            next_rdata[2:0] = irq_mask;
        end else if (hit_setting) begin
            next_rdata[2:0] = wake_mask;
            next_rdata[SET_POL_LSB +: 2] = policy;
        end
    end

    // Single-wait-state ack; it drops in the cycle after it was given.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= (wb_req && !wb_we_i) ? next_rdata : 32'h0000_0000;
        end
    end

    // Software-written registers; only byte lane 0 carries fields.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap      <= CAP_RST;
            irq_mask <= IRQ_MASK_RST;
        end else begin
            if (wr_lane0 && hit_cap) begin
                cap <= wb_dat_i[7:0];
            end
            if (wr_lane0 && hit_mask) begin
                irq_mask <= wb_dat_i[2:0];
            end
        end
    end

    // Stored request settings; either reset restores the defaults.
    // Only bits 2:0 of the mask argument are kept.
    always_ff @(posedge clk_i) begin
        if (rst_i || bus_reset_i) begin
            wake_mask <= WAKE_MASK_RST;
            policy    <= POLICY_RST;
        end else begin
            if (rq.take_wake) begin
                wake_mask <= setup_index_i[2:0];
            end
            if (rq.take_charge) begin
                policy <= setup_index_i[1:0];
            end
        end
    end

    // Request answer and wake pulse, one cycle after the cause.
    assign take_any = rq.take_wake || rq.take_charge;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_ack_o    <= 1'b0;
            req_stall_o  <= 1'b0;
            wake_event_o <= 1'b0;
        end else begin
            req_ack_o    <= take_any;
            req_stall_o  <= rq.reject;
            wake_event_o <= |wake_hit;
        end
    end

    // Sticky status; a new event beats the clear of a read.
    // A read clears only the bits it returned, so an event that lands
    // between the data capture and the ack edge is not lost.
    assign status_set = {rq.reject, take_any, |wake_hit};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status <= STATUS_RST;
            irq_o  <= 1'b0;
        end else begin
            status <= (status & ~(wb_dat_o[2:0] & {3{rd_status_done}}))
                      | status_set;
            irq_o  <= |(status & irq_mask);
        end
    end

    // Charging cap; connector current or a contract takes precedence.
    assign override = typec_above_default_i || pd_contract_i;
    assign high_cap = (HIGH_LIM > negotiated_limit_i)
                      ? HIGH_LIM : negotiated_limit_i;
    assign low_cap  = (LOW_LIM > negotiated_limit_i)
                      ? LOW_LIM : negotiated_limit_i;
    always_comb begin
        next_limit = negotiated_limit_i;
        if (!override) begin
            unique case (policy)
                POL_DEFAULT: next_limit = negotiated_limit_i;
                POL_HIGH:    next_limit = high_cap;
                POL_LOW:     next_limit = low_cap;
                POL_NONE:    next_limit = '0;
            endcase
        end
    end

    // Registered power outputs; extra draw only under codes 01h/02h.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            charge_limit_o   <= '0;
            charge_extra_o   <= 1'b0;
            charge_inhibit_o <= 1'b0;
        end else begin
            charge_limit_o   <= next_limit;
            charge_extra_o   <= !override
                                && (policy == POL_HIGH
                                || policy == POL_LOW);
            charge_inhibit_o <= !override && policy == POL_NONE;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // A request of ours that fails any validity check.
    sequence s_bad_req;
        rq.reject && !bus_reset_i;
    endsequence
    // A stall answer with both settings left alone.
    sequence s_stall_kept;
        req_stall_o && !req_ack_o && $stable(wake_mask) && $stable(policy);
    endsequence

    AST_STALL_KEEPS: assert property (
        s_bad_req |=> s_stall_kept)
        else $error("rejected request changed settings or not stalled");

    AST_STATE_GATE: assert property (
        setup_valid_i && setup_type_i == REQ_TYPE_H2D
        && setup_req_i == SET_FEATURE_REQ && !bus_reset_i
        && !(dev_state_i inside {PFS_ADDRESS, PFS_CONFIGURED})
        |=> req_stall_o)
        else $error("request outside Address/Configured not stalled");

    AST_CAP_GATE: assert property (
        setup_valid_i && setup_type_i == REQ_TYPE_H2D
        && setup_req_i == SET_FEATURE_REQ && !bus_reset_i
        && !cap[CAP_PD_BIT] |=> req_stall_o && !req_ack_o)
        else $error("request without capability bit not stalled");

    AST_WAKE_STORE: assert property (
        rq.take_wake && !bus_reset_i
        |=> req_ack_o && wake_mask == 3'($past(setup_index_i)))
        else $error("wake mask not stored from argument");

    AST_POLICY_STORE: assert property (
        rq.take_charge && !bus_reset_i
        |=> req_ack_o && policy == 2'($past(setup_index_i)))
        else $error("charging policy not stored from argument");

    AST_BAD_CODE: assert property (
        setup_valid_i && setup_value_i == CHARGE_SEL
        && setup_index_i >= POL_LIMIT |-> !rq.take_charge)
        else $error("unusable charging code taken");

    AST_RESET_DEFAULT: assert property (
        bus_reset_i |=> wake_mask == WAKE_MASK_RST
        && policy == POLICY_RST)
        else $error("device reset did not restore defaults");

    AST_ATTACH_WAKE: assert property (
        wake_mask[WAKE_ATTACH] && battery_present_i
        && $past(battery_present_i) == 1'b0 && !$past(rst_i)
        |=> wake_event_o && status[ST_WAKE])
        else $error("battery attach did not wake");

    AST_FLOW_WAKE: assert property (
        wake_mask[WAKE_FLOW] && !$stable(battery_charging_i)
        && !$past(rst_i) |=> wake_event_o)
        else $error("charge flow change did not wake");

    AST_ERROR_WAKE: assert property (
        wake_mask[WAKE_ERROR] && battery_error_i
        && !$past(battery_error_i) && !$past(rst_i) |=> wake_event_o)
        else $error("battery error did not wake");

    AST_MASKED_QUIET: assert property (
        !wake_mask[WAKE_ERROR] && !wake_mask[WAKE_FLOW]
        && !wake_mask[WAKE_ATTACH] |=> !wake_event_o)
        else $error("wake raised with all events masked");

    AST_NO_CHARGE: assert property (
        policy == POL_NONE && !override
        |=> charge_limit_o == '0 && charge_inhibit_o)
        else $error("charging draw allowed under code 03h");

    AST_HIGH_CAP: assert property (
        policy == POL_HIGH && !override
        |=> charge_limit_o >= HIGH_LIM
        && charge_limit_o >= $past(negotiated_limit_i) && charge_extra_o)
        else $error("high-power cap not the larger limit");

    AST_LOW_CAP: assert property (
        policy == POL_LOW && !override
        |=> charge_limit_o >= LOW_LIM
        && charge_limit_o >= $past(negotiated_limit_i))
        else $error("low-power cap not the larger limit");

    AST_DEFAULT_CAP: assert property (
        (policy == POL_DEFAULT || override)
        |=> charge_limit_o == $past(negotiated_limit_i) && !charge_extra_o)
        else $error("default or overridden cap not the negotiated one");
endmodule

// ==== sim/pfs_host_model.sv ====
// Host-side model that issues feature-set setup requests.
// Assumes only the bench calls send and nothing else drives the fields.
`timescale 1ns/100ps
module pfs_host_model (
    input  wire logic        clk_i,    // Device clock.
    output logic             valid_o,  // Setup strobe.
    output logic [7:0]       type_o,   // Request type.
    output logic [7:0]       req_o,    // Request code.
    output logic [15:0]      value_o,  // Selector.
    output logic [15:0]      index_o,  // Argument.
    output logic [15:0]      length_o  // Data length.
);
    // Idle fields carry a pattern so a stale value is never reused.
    initial begin
        valid_o = 1'b0;
        {type_o, req_o, value_o, index_o, length_o} = {8{8'hA5}};
    end
    // One strobe per call; it never waits for an answer, since a hub
    // that is not configured may give none.
    task automatic send(input logic [15:0] s, input logic [15:0] i,
                        input logic [15:0] l);
        @(posedge clk_i);
        valid_o  <= 1'b1;
        type_o   <= 8'h00;
        req_o    <= 8'h03;
        value_o  <= s;
        index_o  <= i;
        length_o <= l;
        @(posedge clk_i);
        valid_o  <= 1'b0;
        {type_o, req_o, value_o, index_o, length_o} <=
            ~{type_o, req_o, value_o, index_o, length_o};
    endtask
endmodule

// ==== sim/tb_pfs_top.sv ====
// Self-checking bench of the feature-set request block.
// Assumes the host model issues every setup strobe.
`timescale 1ns/100ps
module tb_pfs_top;
    import pfs_pkg::*;
    typedef struct packed {
        pfs_dev_state_t st;
        logic [15:0]    s, i, l;
        logic           stall;
        logic [7:0]     set;
        logic [15:0]    lim;
    } pfs_row_t;
    logic           clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic           irq_o, setup_valid_i, bus_reset_i, req_ack_o;
    logic           req_stall_o, battery_present_i, battery_charging_i;
    logic           battery_error_i, wake_event_o, typec_above_default_i;
    logic           pd_contract_i, charge_extra_o, charge_inhibit_o;
    logic [7:0]     wb_adr_i, setup_type_i, setup_req_i;
    logic [3:0]     wb_sel_i;
    logic [31:0]    wb_dat_i, wb_dat_o, rd;
    logic [15:0]    setup_value_i, setup_index_i, setup_length_i;
    logic [15:0]    negotiated_limit_i, charge_limit_o;
    pfs_dev_state_t dev_state_i;
    int             mismatches = 0;
    int             checks = 0;
    pfs_row_t       rows [11];
    pfs_top pfs_top_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o,
        .setup_valid_i, .setup_type_i, .setup_req_i, .setup_value_i,
        .setup_index_i, .setup_length_i, .bus_reset_i, .dev_state_i,
        .req_ack_o, .req_stall_o, .battery_present_i, .battery_charging_i,
        .battery_error_i, .wake_event_o, .typec_above_default_i,
        .pd_contract_i, .negotiated_limit_i, .charge_limit_o,
        .charge_extra_o, .charge_inhibit_o);
    pfs_host_model pfs_host_model_inst (.clk_i, .valid_o(setup_valid_i),
        .type_o(setup_type_i), .req_o(setup_req_i), .value_o(setup_value_i),
        .index_o(setup_index_i), .length_o(setup_length_i));
    // Free-running 200 MHz clock.
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // Counts every comparison and reports a failing one at once.
    task automatic check(input logic ok, input string what);
        checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    // Classic single cycle; the request is held until ack is sampled.
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    endtask
    // One request, its answer looked at in the cycle where it stands.
    task automatic req(input logic [15:0] s, i, l, input logic stall);
        pfs_host_model_inst.send(s, i, l);
        @(negedge clk_i);
        check({req_ack_o, req_stall_o} === {~stall, stall}, "answer");
    endtask
    // A battery input changes, then the wake pulse is looked at.
    task automatic poke(input logic [2:0] v, input logic exp);
        @(posedge clk_i);
        {battery_error_i, battery_charging_i, battery_present_i} <= v;
        @(posedge clk_i);
        @(negedge clk_i);
        check(wake_event_o === exp, "wake");
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Watchdog sized well beyond the hundred or so cycles the tests need.
    initial begin
        repeat (20000) @(posedge clk_i);
        check(1'b0, "timeout");
        give_verdict();
    end
    // Main sequence: reset checks, then table rows, then the other hand-written cases.
    initial begin
        rows[0]  = {PFS_CONFIGURED, 48'h0001_0005_0000, 25'h0_0500_64};
        rows[1]  = {PFS_ADDRESS, 48'h0002_0001_0000, 25'h0_1505_DC};
        rows[2]  = {PFS_CONFIGURED, 48'h0002_0004_0000, 25'h1_1505_DC};
        rows[3]  = {PFS_CONFIGURED, 48'h0003_0001_0000, 25'h1_1505_DC};
        rows[4]  = {PFS_CONFIGURED, 48'h0001_0002_0001, 25'h1_1505_DC};
        rows[5]  = {PFS_DEFAULT, 48'h0001_0002_0000, 25'h1_1505_DC};
        rows[6]  = {PFS_SUSPENDED, 48'h0002_0003_0000, 25'h1_1505_DC};
        rows[7]  = {PFS_CONFIGURED, 48'h0002_0002_0000, 25'h0_2501_F4};
        rows[8]  = {PFS_CONFIGURED, 48'h0002_0003_0000, 25'h0_3500_00};
        rows[9]  = {PFS_CONFIGURED, 48'h0001_0002_0000, 25'h0_3200_00};
        rows[10] = {PFS_CONFIGURED, 48'h0002_0000_0000, 25'h0_0200_64};
        {wb_cyc_i, wb_stb_i, wb_we_i, bus_reset_i, typec_above_default_i} = '0;
        {battery_present_i, battery_charging_i, battery_error_i} = '0;
        {pd_contract_i, wb_adr_i, wb_dat_i} = '0;
        {rst_i, wb_sel_i, negotiated_limit_i} = {1'b1, 4'hF, 16'h0064};
        dev_state_i = PFS_CONFIGURED;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        check({irq_o, req_ack_o, charge_limit_o} === 18'h0, "reset");
        wb(1'b0, ADR_CAP, 32'h0);
        check(rd === 32'h0, "cap reset");
        wb(1'b1, ADR_CAP, 32'h0000_0040);
        wb(1'b1, ADR_IRQ_MASK, 32'h0000_0001);
        foreach (rows[k]) begin
            dev_state_i <= rows[k].st;
            req(rows[k].s, rows[k].i, rows[k].l, rows[k].stall);
            wb(1'b0, ADR_SETTING, 32'h0);
            check(rd === {24'h0, rows[k].set}, "setting");
            check(charge_limit_o === rows[k].lim, "limit");
            check(charge_inhibit_o === (rows[k].set[5:4] == POL_NONE),
                  "inhibit");
            check(charge_extra_o === (rows[k].set[5:4] inside
                  {POL_HIGH, POL_LOW}), "extra");
            $display("row %0d done", k);
        end
        req(16'h0001, 16'h0007, 16'h0000, 1'b0);
        poke(3'h1, 1'b1);
        poke(3'h3, 1'b1);
        poke(3'h1, 1'b1);
        poke(3'h5, 1'b1);
        req(16'h0001, 16'h0003, 16'h0000, 1'b0);
        poke(3'h1, 1'b0);
        poke(3'h5, 1'b0);
        check(irq_o === 1'b1, "irq high");
        wb(1'b0, ADR_STATUS, 32'h0);
        check(rd === 32'h0000_0007, "status");
        wb(1'b0, ADR_STATUS, 32'h0);
        check({rd, irq_o} === 33'h0, "status clear");
        $display("wake and irq done");
        req(16'h0002, 16'h0001, 16'h0000, 1'b0);
        @(posedge clk_i);
        typec_above_default_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        check({charge_extra_o, charge_limit_o} === 17'h0064, "cc");
        @(posedge clk_i);
        {typec_above_default_i, pd_contract_i} <= 2'b01;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        check({charge_extra_o, charge_limit_o} === 17'h0064, "override");
        @(posedge clk_i);
        bus_reset_i <= 1'b1;
        @(posedge clk_i);
        bus_reset_i <= 1'b0;
        wb(1'b0, ADR_SETTING, 32'h0);
        check(rd === 32'h0, "bus reset");
        wb(1'b1, ADR_CAP, 32'h0);
        req(16'h0001, 16'h0001, 16'h0000, 1'b1);
        wb(1'b0, 8'h10, 32'h0);
        check(rd === 32'h0, "unmapped");
        $display("override, reset and capability done");
        give_verdict();
    end
endmodule
